// ---- logic/srl_defines.vh ----
`ifndef SRL_DEFINES_VH
`define SRL_DEFINES_VH

// register indices, byte address equals index
`define SRL_ADDR_W            4
`define SRL_DATA_W            8
`define SRL_OFF_CTRL_ZERO     4'h0
`define SRL_OFF_CLK_ENABLE    4'h1
`define SRL_OFF_STATUS        4'h2

// control zero fields
`define SRL_BIT_LATCH_EN      7
`define SRL_DIV_SEL_HI        6
`define SRL_DIV_SEL_LO        4
`define SRL_BIT_TRUE_OE       3
`define SRL_BIT_INV_OE        2
`define SRL_BIT_SOFT_SET      1
`define SRL_BIT_SOFT_RESET    0
`define SRL_CTRL_ZERO_RST     8'h00

// clock enable fields
`define SRL_BIT_SET_CLK_EN    6
`define SRL_BIT_RESET_CLK_EN  2
`define SRL_CLK_ENABLE_RST    8'h00

// status fields
`define SRL_BIT_STAT_Q        0
`define SRL_BIT_STAT_SET      1
`define SRL_BIT_STAT_RESET    2

// divider: shortest period 4 = 2**2, longest 512 = 2**9
`define SRL_DIV_SEL_W         3
`define SRL_DIV_CNT_W         9
`define SRL_DIV_MIN_LOG2      2

// one instruction clock lasts four system clocks
`define SRL_INSTR_CYCLES      3'h4
`define SRL_PULSE_CNT_W       3

`endif

// ---- logic/srl_divider.v ----
`include "srl_defines.vh"

module srl_divider (
  input  wire                        clk_sys,
  input  wire                        rst_sync_n,
  input  wire                        clk_en,
  input  wire [`SRL_DIV_SEL_W-1:0]   divider_select,
  output reg                         div_pulse
);

  reg  [`SRL_DIV_CNT_W-1:0] count_reg;
  wire [`SRL_DIV_CNT_W-1:0] wrap_mask;
  wire [3:0]                sel_plus;

  assign sel_plus = {1'b0, divider_select} + 4'h2;

  // mask of the low bits that make up one period
  genvar i;
  generate
    for (i = 0; i < `SRL_DIV_CNT_W; i = i + 1) begin : g_mask
      assign wrap_mask[i] = (i < sel_plus);
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_reg <= {`SRL_DIV_CNT_W{1'b0}};
    end else if (clk_en) begin
      count_reg <= count_reg + 9'h001;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_pulse <= 1'b0;
    end else if (clk_en) begin
      div_pulse <= ((count_reg & wrap_mask) == wrap_mask);
    end
  end

endmodule

// ---- logic/srl_latch_ctrl.v ----
// Behaviour
// - latch enable bit 7 of control zero turns the latch outputs on; set and reset act on the latch either way
// - divider pulse one clock wide every 4 to 512 clocks by select
// - enabled latch with true enable drives true output pin
// - true enable zero keeps the true output disabled
// - inverted enable drives inverted pin when latch enabled, else disabled
// - latch enable zero makes both output enables ineffective
// - writing one to soft set pulses set for one instruction clock
// - writing one to soft reset pulses reset for one instruction clock
// - soft pulse bits are set only and always read zero
// - writing zero to soft pulse bits has no effect
// - set and reset together give reset, reset dominates
// - latch is level sensitive with active high set and reset
// - divider pulse drives set or reset only when its enable is one
`include "srl_defines.vh"

module srl_latch_ctrl (
  input  wire                     clk_sys,
  input  wire                     rst_n,
  input  wire                     clk_en,
  input  wire [`SRL_ADDR_W-1:0]   reg_addr,
  input  wire [`SRL_DATA_W-1:0]   reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`SRL_DATA_W-1:0]   reg_rdata,
  output reg                      true_output_pin,
  output reg                      true_output_pin_oe,
  output reg                      inverted_output_pin,
  output reg                      inverted_output_pin_oe
);

  reg                          rst_meta_reg;
  reg                          rst_sync_reg;
  wire                         rst_sync_n;

  reg                          latch_enable_reg;
  reg  [`SRL_DIV_SEL_W-1:0]    divider_select_reg;
  reg                          true_output_enable_reg;
  reg                          inverted_output_enable_reg;
  reg                          set_clock_enable_reg;
  reg                          reset_clock_enable_reg;
  reg  [`SRL_PULSE_CNT_W-1:0]  soft_set_cnt_reg;
  reg  [`SRL_PULSE_CNT_W-1:0]  soft_reset_cnt_reg;
  reg                          latch_q_reg;

  wire                         div_pulse;
  wire                         wr_ctrl;
  wire                         wr_clk;
  wire                         set_in;
  wire                         reset_in;
  wire                         latch_q_next;
  wire                         true_oe_next;
  wire                         inv_oe_next;
  reg  [`SRL_DATA_W-1:0]       rdata_next;

  // reset release through two flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_sync_n = rst_sync_reg;

  assign wr_ctrl = reg_wr && (reg_addr == `SRL_OFF_CTRL_ZERO);
  assign wr_clk  = reg_wr && (reg_addr == `SRL_OFF_CLK_ENABLE);

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      latch_enable_reg           <= 1'b0;
      divider_select_reg         <= 3'h0;
      true_output_enable_reg     <= 1'b0;
      inverted_output_enable_reg <= 1'b0;
      set_clock_enable_reg       <= 1'b0;
      reset_clock_enable_reg     <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        latch_enable_reg           <= reg_wdata[`SRL_BIT_LATCH_EN];
        divider_select_reg         <=
          reg_wdata[`SRL_DIV_SEL_HI:`SRL_DIV_SEL_LO];
        true_output_enable_reg     <= reg_wdata[`SRL_BIT_TRUE_OE];
        inverted_output_enable_reg <= reg_wdata[`SRL_BIT_INV_OE];
      end
      if (wr_clk) begin
        set_clock_enable_reg   <= reg_wdata[`SRL_BIT_SET_CLK_EN];
        reset_clock_enable_reg <= reg_wdata[`SRL_BIT_RESET_CLK_EN];
      end
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_set_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl && reg_wdata[`SRL_BIT_SOFT_SET]) begin
        soft_set_cnt_reg <= `SRL_INSTR_CYCLES;
      end else if (soft_set_cnt_reg != 3'h0) begin
        soft_set_cnt_reg <= soft_set_cnt_reg - 3'h1;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_reset_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl && reg_wdata[`SRL_BIT_SOFT_RESET]) begin
        soft_reset_cnt_reg <= `SRL_INSTR_CYCLES;
      end else if (soft_reset_cnt_reg != 3'h0) begin
        soft_reset_cnt_reg <= soft_reset_cnt_reg - 3'h1;
      end
    end
  end

  srl_divider u_divider (
    .clk_sys        (clk_sys),
    .rst_sync_n     (rst_sync_n),
    .clk_en         (clk_en),
    .divider_select (divider_select_reg),
    .div_pulse      (div_pulse)
  );

  assign set_in   = (soft_set_cnt_reg != 3'h0) ||
                    (div_pulse && set_clock_enable_reg);
  assign reset_in = (soft_reset_cnt_reg != 3'h0) ||
                    (div_pulse && reset_clock_enable_reg);

  assign latch_q_next = reset_in ? 1'b0 : (set_in ? 1'b1 : latch_q_reg);

  // no reset value for the latch
  always @(posedge clk_sys) begin
    if (clk_en) begin
      latch_q_reg <= latch_q_next;
    end
  end

  assign true_oe_next = latch_enable_reg && true_output_enable_reg;
  assign inv_oe_next  = latch_enable_reg && inverted_output_enable_reg;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      true_output_pin        <= 1'b0;
      true_output_pin_oe     <= 1'b0;
      inverted_output_pin    <= 1'b0;
      inverted_output_pin_oe <= 1'b0;
    end else if (clk_en) begin
      true_output_pin        <= true_oe_next && latch_q_next;
      true_output_pin_oe     <= true_oe_next;
      inverted_output_pin    <= inv_oe_next && !latch_q_next;
      inverted_output_pin_oe <= inv_oe_next;
    end
  end

  // read mux
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `SRL_OFF_CTRL_ZERO: begin
        rdata_next[`SRL_BIT_LATCH_EN] = latch_enable_reg;
        rdata_next[`SRL_DIV_SEL_HI:`SRL_DIV_SEL_LO] = divider_select_reg;
        rdata_next[`SRL_BIT_TRUE_OE] = true_output_enable_reg;
        rdata_next[`SRL_BIT_INV_OE]  = inverted_output_enable_reg;
      end
      `SRL_OFF_CLK_ENABLE: begin
        rdata_next[`SRL_BIT_SET_CLK_EN]   = set_clock_enable_reg;
        rdata_next[`SRL_BIT_RESET_CLK_EN] = reset_clock_enable_reg;
      end
      `SRL_OFF_STATUS: begin
        rdata_next[`SRL_BIT_STAT_Q]     = latch_q_reg;
        rdata_next[`SRL_BIT_STAT_SET]   = set_in;
        rdata_next[`SRL_BIT_STAT_RESET] = reset_in;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

endmodule

// ---- tb/srl_latch_ctrl_sva.sv ----
module srl_latch_ctrl_sva (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       clk_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       true_output_pin,
  input wire       true_output_pin_oe,
  input wire       inverted_output_pin,
  input wire       inverted_output_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wr0;
  assign wr0 = clk_en && reg_wr && reg_addr == 4'h0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_rd_soft_zero: assert property (
    clk_en && reg_rd && reg_addr == 4'h0 |=> reg_rdata[1:0] == 2'h0)
    else $error("pulse bits read back nonzero");
  a_true_gate: assert property (
    !true_output_pin_oe [*2] |-> !true_output_pin)
    else $error("true pin high while disabled");
  a_inv_gate: assert property (
    !inverted_output_pin_oe [*2] |-> !inverted_output_pin)
    else $error("inverted pin high while disabled");
  a_pins_opposed: assert property (
    (true_output_pin_oe && inverted_output_pin_oe) [*3]
    |-> true_output_pin ^ inverted_output_pin)
    else $error("true and inverted pins agree");
  a_oe_cause: assert property (
    $changed(true_output_pin_oe) |-> $past(wr0) || $past(wr0, 2))
    else $error("true enable moved without a write");
  a_disable_off: assert property (
    wr0 && !reg_wdata[7] ##1 clk_en && !wr0
    |=> !true_output_pin_oe && !inverted_output_pin_oe)
    else $error("enable active with latch off");
  a_set_pulse: assert property (
    wr0 && reg_wdata == 8'h8e ##1 (clk_en && !reg_wr) [*2]
    |=> true_output_pin && !inverted_output_pin)
    else $error("soft set had no effect");
  a_reset_wins: assert property (
    wr0 && reg_wdata == 8'h8f ##1 (clk_en && !reg_wr) [*2]
    |=> !true_output_pin && inverted_output_pin)
    else $error("set beat reset");
  c_both: cover property (wr0 && reg_wdata == 8'h8f);
  c_stat: cover property (clk_en && reg_rd && reg_addr == 4'h2);
  c_pins: cover property (true_output_pin && inverted_output_pin_oe);
endmodule

bind srl_latch_ctrl srl_latch_ctrl_sva u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .true_output_pin(true_output_pin),
  .true_output_pin_oe(true_output_pin_oe),
  .inverted_output_pin(inverted_output_pin),
  .inverted_output_pin_oe(inverted_output_pin_oe)
);

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  wire  [7:0] reg_rdata;
  wire        tp, toe, ip, ioe;
  int         mismatches = 0;
  int         num_checks = 0;

  srl_latch_ctrl dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .true_output_pin(tp), .true_output_pin_oe(toe),
    .inverted_output_pin(ip), .inverted_output_pin_oe(ioe)
  );

  always #4 clk_sys = ~clk_sys;

  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task t_regs;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    rd(4'h0, 8'h00);
    $display("done regs");
  endtask

  task t_pins;
    logic [7:0] w [8] = '{8'h02, 8'h0c, 8'h8c, 8'h84,
                          8'h8d, 8'h88, 8'h8e, 8'h8f};
    logic [3:0] e [8] = '{4'h0, 4'h0, 4'hd, 4'h1,
                          4'h7, 4'h4, 4'hd, 4'h7};
    int k;
    wr(4'h0, 8'h02);
    for (k = 0; k < 8; k++) begin
      wr(4'h0, w[k]);
      repeat (6) @(posedge clk_sys);
      #1;
      chk({tp, toe, ip, ioe}, e[k]);
      if (k == 0) rd(4'h2, 8'h01);
      if (k == 6) rd(4'h0, 8'h8c);
    end
    $display("done pins");
  endtask

  task t_frz;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(4'h0, 8'h00);
    clk_en <= 1'b1;
    rd(4'h0, 8'h8c);
    $display("done freeze");
  endtask

  task t_div;
    int s, i, f, d, n;
    logic oth;
    for (s = 0; s < 8; s++) begin
      wr(4'h0, {1'b0, s[2:0], 4'h0});
      wr(4'h1, s[0] ? 8'h04 : 8'h40);
      @(posedge clk_sys);
      reg_addr <= 4'h2;
      reg_rd <= 1'b1;
      n = 0;
      d = 0;
      f = 0;
      oth = 1'b0;
      for (i = 0; i < 1100 && n < 2; i++) begin
        @(posedge clk_sys);
        #1;
        if (reg_rdata[s[0] ? 2 : 1] === 1'b1) begin
          if (n == 0) f = i;
          else d = i - f;
          n++;
        end
        oth = oth | reg_rdata[s[0] ? 1 : 2];
      end
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      chk(d[15:0], 16'h0004 << s);
      chk({15'h0, oth}, 16'h0000);
    end
    $display("done divider");
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_sim;
  end

  initial begin
    t_regs;
    t_pins;
    t_frz;
    t_div;
    t_regs;
    end_sim;
  end
endmodule
